// ==== sfprc_dev.sv ====
// flash device end: power modes, deep sleep, power-on and pin reset sequencing
`timescale 1ns/10ps

// Function
// R1: chip select low means active state
// R2: stay active while internal operation runs
// R3: select high and idle gives standby
// R4: sleep command from standby enters deep sleep
// R5: sleep command accepted only when not busy
// R6: deep sleep ignores everything but wake
// R7: wake command returns standby after wake delay
// R8: sleep begins after select high plus entry delay
// R9: wake starts on select high, ends after delay
// R10: host keeps select still during wake
// R11: power-on reset runs for the powerup delay
// R12: host stays deselected during powerup delay
// R13: pin resets when deselected long or quad off
// R14: reset pin ignored during power-on reset
// R15: host waits reset hold after late pin release
// R16: host keeps pin high before reset pulse
// R17: qualifying low pulse restores registers, holds busy
// R18: outputs released in sleep and reset
module sfprc_dev import sfprc_pkg::*; #(
	parameter int POWERUP_CYC = POWERUP_DEV_CYC
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_b,
	// supply monitor
	input  wire logic          vcc_ok,
	// core status and configuration
	input  wire logic          busy_flag,
	input  wire logic          quad_enable,
	// link to the host
	sfprc_if.dev               lnk,
	// state seen by the core
	output sfprc_pstate_t      power_state,
	output logic               in_reset,
	output logic               reg_restore
);

	typedef struct packed {
		logic [SY_W-1:0] s1;
		logic [SY_W-1:0] s2;
		logic            sck_d;
		logic            cs_d;
		sfprc_pstate_t   st;
		sfprc_cnt_t      cnt;
		logic [7:0]      shreg;
		logic [3:0]      nbits;
		logic [7:0]      opcode;
		sfprc_short_t    cs_hi;
		sfprc_short_t    rst_lo;
		logic            miso;
		logic            miso_oe;
		logic            in_reset;
		logic            reg_restore;
	} sfprc_dev_state_t;

	sfprc_dev_state_t s;
	sfprc_dev_state_t next_s;

	logic cs_high;
	logic sck_lvl;
	logic mosi_lvl;
	logic pin_lvl;
	logic vcc_lvl;
	logic sck_rise;
	logic cs_rise;
	logic cs_fall;
	logic pin_is_reset;

	// ----------------------------------------------------------------
	// synchronised link view
	// ----------------------------------------------------------------
	assign cs_high  = s.s2[SY_CS];
	assign sck_lvl  = s.s2[SY_SCK];
	assign mosi_lvl = s.s2[SY_MOSI];
	assign pin_lvl  = s.s2[SY_DL3];
	assign vcc_lvl  = s.s2[SY_VCC];
	assign sck_rise = sck_lvl & ~s.sck_d;
	assign cs_rise  = cs_high & ~s.cs_d;
	assign cs_fall  = ~cs_high & s.cs_d;

	// quad traffic may leave the line low briefly, so wait out the select-high time
	assign pin_is_reset = ~quad_enable | (s.cs_hi > sfprc_short_t'(SELECT_HIGH_CYC)); // R13

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.s1 = {vcc_ok, lnk.dl3, lnk.mosi, lnk.sck, lnk.cs_n};
		next_s.s2 = s.s1;
		next_s.sck_d = sck_lvl;
		next_s.cs_d = cs_high;
		next_s.reg_restore = 1'b0;
		if (s.cnt != '0) begin
			next_s.cnt = s.cnt - sfprc_cnt_t'(1);
		end

		// deselect time, saturating just past the threshold
		if (!cs_high) begin
			next_s.cs_hi = '0;
		end else if (s.cs_hi <= sfprc_short_t'(SELECT_HIGH_CYC)) begin
			next_s.cs_hi = s.cs_hi + sfprc_short_t'(1);
		end

		// low time of the reset pin while it acts as reset
		if (!pin_is_reset || pin_lvl) begin
			next_s.rst_lo = '0;
		end else if (s.rst_lo <= sfprc_short_t'(RESET_PULSE_CYC)) begin
			next_s.rst_lo = s.rst_lo + sfprc_short_t'(1);
		end

		// opcode shifter, mode 0: sample on the rising clock edge
		if (cs_fall) begin
			next_s.nbits = '0;
			next_s.opcode = '0;
		end else if (!cs_high && sck_rise && s.nbits != 4'(OPC_BITS)) begin
			next_s.shreg = {s.shreg[6:0], mosi_lvl};
			next_s.nbits = s.nbits + 4'(1);
			if (s.nbits == 4'(OPC_BITS - 1)) begin
				next_s.opcode = {s.shreg[6:0], mosi_lvl};
			end
		end

		case (s.st)
			PS_POR: begin
				if (!vcc_lvl) begin
					next_s.cnt = sfprc_cnt_t'(POWERUP_CYC);
				end else if (s.cnt == '0) begin
					next_s.st = PS_STANDBY; // R11
				end
			end
			PS_STANDBY: begin
				if (!cs_high || busy_flag) begin
					next_s.st = PS_ACTIVE; // R1
				end
			end
			PS_ACTIVE: begin
				if (cs_rise && s.opcode == OPC_SLEEP && !busy_flag) begin
					next_s.st = PS_SLEEP_PEND; // R4 R5 R8
					next_s.cnt = sfprc_cnt_t'(SLEEP_ENTRY_CYC);
				end else if (cs_high && !busy_flag) begin
					next_s.st = PS_STANDBY; // R3
				end
				// otherwise busy keeps it active after deselect: R2
			end
			PS_SLEEP_PEND: begin
				if (s.cnt == '0) begin
					next_s.st = PS_SLEEP; // R8
				end
			end
			PS_SLEEP: begin
				if (cs_rise && s.opcode == OPC_WAKE) begin
					next_s.st = PS_WAKE; // R9
					next_s.cnt = sfprc_cnt_t'(WAKE_CYC);
				end
				// any other command leaves it asleep: R6
			end
			PS_WAKE: begin
				if (s.cnt == '0) begin
					next_s.st = PS_STANDBY; // R7
				end
			end
			PS_HWRST: begin
				next_s.opcode = '0;
				next_s.nbits = '0;
				if (s.cnt == '0) begin
					next_s.st = cs_high ? PS_STANDBY : PS_ACTIVE;
				end
			end
			default: begin
				next_s.st = PS_POR;
			end
		endcase

		// pin reset outranks every mode except power-on reset
		if (s.st != PS_POR && s.rst_lo == sfprc_short_t'(RESET_PULSE_CYC)) begin // R14
			next_s.st = PS_HWRST; // R17
			// hold runs from the pin's fall, so the qualify and sync time is already spent
			next_s.cnt = sfprc_cnt_t'(RESET_HOLD_CYC - RESET_PULSE_CYC - SYNC_MARGIN_CYC);
			next_s.reg_restore = 1'b1;
			next_s.opcode = '0;
			next_s.nbits = '0;
		end
		// a supply dip restarts the full power-on sequence
		if (!vcc_lvl) begin
			next_s.st = PS_POR;
			next_s.cnt = sfprc_cnt_t'(POWERUP_CYC);
		end

		next_s.in_reset = (next_s.st == PS_POR) || (next_s.st == PS_HWRST);
		// device answers with its busy flag only while awake and selected
		next_s.miso = busy_flag;
		next_s.miso_oe = !cs_high && (next_s.st == PS_ACTIVE); // R18
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s <= '{
				s1: '0,
				s2: '0,
				sck_d: 1'b0,
				cs_d: 1'b0,
				st: PS_POR,
				cnt: '0,
				shreg: '0,
				nbits: '0,
				opcode: '0,
				cs_hi: '0,
				rst_lo: '0,
				miso: 1'b0,
				miso_oe: 1'b0,
				in_reset: 1'b1,
				reg_restore: 1'b0
			};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign power_state  = s.st;
	assign in_reset     = s.in_reset;
	assign reg_restore  = s.reg_restore;
	assign lnk.miso     = s.miso;
	assign lnk.miso_oe  = s.miso_oe;

endmodule

// ==== sfprc_pkg.sv ====
// shared constants, timing figures and types for the flash power and reset sequencer
package sfprc_pkg;

	// ----------------------------------------------------------------
	// clock and time conversion
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;

	// least time: round up, never below one cycle
	function automatic int ns_to_cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		ns_to_cyc_min = (c < 1) ? 1 : c;
	endfunction

	// longest time: round down, never below one cycle
	function automatic int ns_to_cyc_max(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		ns_to_cyc_max = (c < 1) ? 1 : c;
	endfunction

	// ----------------------------------------------------------------
	// timing figures
	// ----------------------------------------------------------------
	localparam int POWERUP_DELAY_NS       = 300000;
	localparam int SLEEP_ENTRY_DELAY_NS   = 3000;
	localparam int WAKE_DELAY_NS          = 3000;
	localparam int SELECT_HIGH_TIME_NS    = 50;
	localparam int RESET_PULSE_WIDTH_NS   = 200;
	localparam int RESET_PULSE_HOLD_NS    = 35000;
	localparam int RESET_SETUP_TIME_NS    = 50;
	localparam int RESET_HOLD_TIME_NS     = 50;
	localparam int SCK_PERIOD_NS          = 80;

	localparam int POWERUP_DEV_CYC  = ns_to_cyc_max(POWERUP_DELAY_NS);
	localparam int POWERUP_HOST_CYC = ns_to_cyc_min(POWERUP_DELAY_NS);
	localparam int SLEEP_ENTRY_CYC  = ns_to_cyc_max(SLEEP_ENTRY_DELAY_NS);
	localparam int WAKE_CYC         = ns_to_cyc_max(WAKE_DELAY_NS);
	localparam int SELECT_HIGH_CYC  = ns_to_cyc_min(SELECT_HIGH_TIME_NS);
	localparam int RESET_PULSE_CYC  = ns_to_cyc_min(RESET_PULSE_WIDTH_NS);
	localparam int RESET_HOLD_CYC   = ns_to_cyc_min(RESET_PULSE_HOLD_NS);
	localparam int RESET_SETUP_CYC  = ns_to_cyc_min(RESET_SETUP_TIME_NS);
	localparam int RESET_RH_CYC     = ns_to_cyc_min(RESET_HOLD_TIME_NS);
	localparam int SCK_HALF_CYC     = SCK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	// covers the device's two-flop synchroniser plus its edge detector
	localparam int SYNC_MARGIN_CYC  = 4;

	// ----------------------------------------------------------------
	// commands and widths
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_SLEEP = 8'hb9;
	localparam logic [7:0] OPC_WAKE  = 8'hab;
	localparam int CNT_W    = 16;
	localparam int SHORT_W  = 8;
	localparam int OPC_BITS = 8;

	// synchroniser bit positions in the device
	localparam int SY_CS   = 0;
	localparam int SY_SCK  = 1;
	localparam int SY_MOSI = 2;
	localparam int SY_DL3  = 3;
	localparam int SY_VCC  = 4;
	localparam int SY_W    = 5;

	typedef logic [CNT_W-1:0]   sfprc_cnt_t;
	typedef logic [SHORT_W-1:0] sfprc_short_t;

	typedef enum logic [2:0] {
		PS_POR        = 3'h0,
		PS_STANDBY    = 3'h1,
		PS_ACTIVE     = 3'h2,
		PS_SLEEP_PEND = 3'h3,
		PS_SLEEP      = 3'h4,
		PS_WAKE       = 3'h5,
		PS_HWRST      = 3'h6
	} sfprc_pstate_t;

	typedef enum logic [2:0] {
		HS_POR       = 3'h0,
		HS_IDLE      = 3'h1,
		HS_SHIFT     = 3'h2,
		HS_GAP       = 3'h3,
		HS_RST_SETUP = 3'h4,
		HS_RST_LOW   = 3'h5,
		HS_RST_HOLD  = 3'h6
	} sfprc_hstate_t;

endpackage

// ==== sfprc_if.sv ====
// link between the serial host and the flash power and reset sequencer
`timescale 1ns/10ps
interface sfprc_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic dl3_host;
	logic dl3_host_oe;
	logic dl3;

	// data_line_three has an internal pull-up on the device side
	assign dl3 = dl3_host_oe ? dl3_host : 1'b1;

	modport dev (
		input  cs_n,
		input  sck,
		input  mosi,
		input  dl3,
		output miso,
		output miso_oe
	);

	modport host (
		output cs_n,
		output sck,
		output mosi,
		output dl3_host,
		output dl3_host_oe,
		input  miso,
		input  miso_oe
	);
endinterface

// ==== sfprc_host.sv ====
// host end: deselect through powerup, opcode shifting, sleep/wake pacing, pin reset pulses
`timescale 1ns/10ps
module sfprc_host import sfprc_pkg::*; #(
	parameter int POWERUP_CYC = POWERUP_HOST_CYC
) (
	// clock and reset
	input  wire logic  clk_sys,
	input  wire logic  rst_b,
	// user requests
	input  wire logic  cmd_valid,
	input  wire logic  [7:0] cmd_opcode,
	input  wire logic  hw_reset_req,
	output logic       ready,
	output logic       done,
	// link to the device
	sfprc_if.host      lnk
);

	typedef struct packed {
		sfprc_hstate_t st;
		sfprc_cnt_t    cnt;
		logic [2:0]    ph;
		logic [7:0]    shreg;
		logic [3:0]    nbits;
		logic [7:0]    last;
		logic          cs_n;
		logic          sck;
		logic          mosi;
		logic          dl3;
		logic          ready;
		logic          done;
	} sfprc_host_state_t;

	sfprc_host_state_t s;
	sfprc_host_state_t next_s;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (s.cnt != '0) begin
			next_s.cnt = s.cnt - sfprc_cnt_t'(1);
		end
		case (s.st)
			HS_POR: begin
				if (s.cnt == '0) begin
					next_s.st = HS_IDLE; // R12
					next_s.ready = 1'b1;
				end
			end
			HS_IDLE: begin
				if (hw_reset_req) begin
					// wait out select-high so the pin counts as reset, and the setup time
					next_s.st = HS_RST_SETUP; // R16
					next_s.cnt = sfprc_cnt_t'(RESET_SETUP_CYC + SELECT_HIGH_CYC + SYNC_MARGIN_CYC);
					next_s.ready = 1'b0;
				end else if (cmd_valid) begin
					next_s.st = HS_SHIFT;
					next_s.shreg = cmd_opcode;
					next_s.last = cmd_opcode;
					next_s.nbits = 4'(OPC_BITS);
					next_s.ph = '0;
					next_s.cs_n = 1'b0;
					next_s.mosi = cmd_opcode[7];
					next_s.ready = 1'b0;
				end
			end
			HS_SHIFT: begin
				next_s.ph = s.ph + 3'(1);
				next_s.sck = (next_s.ph >= 3'(SCK_HALF_CYC));
				if (s.ph == 3'(2 * SCK_HALF_CYC - 1)) begin
					next_s.ph = '0;
					next_s.sck = 1'b0;
					next_s.shreg = {s.shreg[6:0], 1'b0};
					next_s.mosi = s.shreg[6];
					next_s.nbits = s.nbits - 4'(1);
					if (s.nbits == 4'(1)) begin
						next_s.st = HS_GAP;
						next_s.cs_n = 1'b1;
						next_s.mosi = 1'b0;
						// clock stays idle and select still until sleep or wake settles
						if (s.last == OPC_WAKE) begin
							next_s.cnt = sfprc_cnt_t'(WAKE_CYC + SYNC_MARGIN_CYC); // R10
						end else if (s.last == OPC_SLEEP) begin
							next_s.cnt = sfprc_cnt_t'(SLEEP_ENTRY_CYC + SYNC_MARGIN_CYC);
						end else begin
							next_s.cnt = sfprc_cnt_t'(SELECT_HIGH_CYC + SYNC_MARGIN_CYC);
						end
					end
				end
			end
			HS_GAP, HS_RST_HOLD: begin
				if (s.cnt == '0) begin
					next_s.st = HS_IDLE;
					next_s.ready = 1'b1;
					next_s.done = 1'b1;
				end
			end
			HS_RST_SETUP: begin
				if (s.cnt == '0) begin
					next_s.st = HS_RST_LOW;
					next_s.dl3 = 1'b0;
					next_s.cnt = sfprc_cnt_t'(RESET_PULSE_CYC + SYNC_MARGIN_CYC);
				end
			end
			HS_RST_LOW: begin
				if (s.cnt == '0) begin
					// select stays high for the whole pulse hold and then for the reset hold time as well
					next_s.st = HS_RST_HOLD; // R15
					next_s.dl3 = 1'b1;
					next_s.cnt = sfprc_cnt_t'(RESET_HOLD_CYC + RESET_RH_CYC);
				end
			end
			default: begin
				next_s.st = HS_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s <= '{
				st: HS_POR,
				// device starts its count only once it sees the supply through its synchroniser
				cnt: sfprc_cnt_t'(POWERUP_CYC + SYNC_MARGIN_CYC),
				ph: '0,
				shreg: '0,
				nbits: '0,
				last: '0,
				cs_n: 1'b1,
				sck: 1'b0,
				mosi: 1'b0,
				dl3: 1'b1,
				ready: 1'b0,
				done: 1'b0
			};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ready           = s.ready;
	assign done            = s.done;
	assign lnk.cs_n        = s.cs_n;
	assign lnk.sck         = s.sck;
	assign lnk.mosi        = s.mosi;
	assign lnk.dl3_host    = s.dl3;
	assign lnk.dl3_host_oe = 1'b1;

endmodule

// ==== sfprc_properties.sv ====
// assertion checker for the flash power and reset sequencer link
`timescale 1ns/10ps
module sfprc_properties import sfprc_pkg::*; (
	// clock and reset
	input wire logic          clk_sys,
	input wire logic          rst_b,
	// link signals
	input wire logic          cs_n,
	input wire logic          miso_oe,
	input wire logic          dl3,
	// device side
	input wire logic          busy_flag,
	input wire sfprc_pstate_t power_state,
	input wire logic          in_reset,
	input wire logic          reg_restore
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// cycles spent in sleep entry and wake, so their length can be bounded
	int hold_cnt;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			hold_cnt <= 0;
		else
			hold_cnt <= (power_state inside {PS_SLEEP_PEND, PS_WAKE}) ? hold_cnt + 1 : 0;
	end

	a_select_gives_active: assert property ($fell(cs_n) && power_state == PS_STANDBY |-> ##[2:5] power_state == PS_ACTIVE)
		else $error("select low did not give active");
	a_busy_keeps_active: assert property (power_state == PS_ACTIVE && busy_flag |=> power_state inside {PS_ACTIVE, PS_HWRST, PS_POR})
		else $error("active left while busy");
	a_idle_gives_standby: assert property ($rose(cs_n) ##1 (cs_n && !busy_flag)[*5] |-> power_state != PS_ACTIVE)
		else $error("still active when deselected and idle");
	a_sleep_needs_idle: assert property ($rose(power_state == PS_SLEEP_PEND) |-> !$past(busy_flag) && cs_n)
		else $error("sleep accepted while busy or selected");
	a_sleep_entry_delay: assert property ($rose(power_state == PS_SLEEP) |-> $past(power_state) == PS_SLEEP_PEND && hold_cnt inside {[290:310]})
		else $error("sleep entered without entry delay");
	a_sleep_ignores_cmds: assert property (power_state == PS_SLEEP |=> power_state inside {PS_SLEEP, PS_WAKE, PS_POR, PS_HWRST})
		else $error("sleep left other than by wake");
	a_wake_start: assert property ($rose(power_state == PS_WAKE) |-> $past(power_state) == PS_SLEEP && cs_n)
		else $error("wake started wrongly");
	a_wake_delay: assert property ($past(power_state) == PS_WAKE && power_state == PS_STANDBY |-> hold_cnt inside {[290:310]})
		else $error("wake ended without wake delay");
	a_quiet_outputs: assert property (power_state inside {PS_SLEEP, PS_POR, PS_HWRST} && $stable(power_state) |-> !miso_oe)
		else $error("output driven in sleep or reset");
	a_restore_on_pulse: assert property (reg_restore |-> power_state == PS_HWRST && in_reset && !$past(dl3, 20))
		else $error("register restore without qualified pulse");
	a_por_ignores_pin: assert property (power_state == PS_POR |=> !reg_restore)
		else $error("reset pin acted during power-on reset");
endmodule

// ==== testbench.sv ====
// self-checking bench joining the host and device ends of the sequencer
`timescale 1ns/10ps
module testbench;
	import sfprc_pkg::*;
	// short power-up keeps the run brief; both ends use the same value
	localparam int PU = 50;
	logic          clk_sys;
	logic          rst_b;
	logic          vcc_ok;
	logic          busy_flag;
	logic          quad_enable;
	logic          cmd_valid;
	logic [7:0]    cmd_opcode;
	logic          hw_reset_req;
	logic          ready;
	logic          done;
	sfprc_pstate_t power_state;
	logic          in_reset;
	logic          reg_restore;
	int            n_errors;
	int            cmp_count;
	int            seed;
	int            m_state;
	int            restore_q[$];

	sfprc_if lnk_if();
	sfprc_dev #(.POWERUP_CYC(PU)) sfprc_dev_inst (.clk_sys(clk_sys), .rst_b(rst_b), .vcc_ok(vcc_ok),
		.busy_flag(busy_flag), .quad_enable(quad_enable), .lnk(lnk_if), .power_state(power_state),
		.in_reset(in_reset), .reg_restore(reg_restore));
	sfprc_host #(.POWERUP_CYC(PU)) sfprc_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .hw_reset_req(hw_reset_req), .ready(ready), .done(done), .lnk(lnk_if));
	sfprc_properties sfprc_properties_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cs_n(lnk_if.cs_n),
		.miso_oe(lnk_if.miso_oe), .dl3(lnk_if.dl3), .busy_flag(busy_flag), .power_state(power_state),
		.in_reset(in_reset), .reg_restore(reg_restore));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (reg_restore === 1'b1)
			restore_q.push_back(int'($time));
	end

	// --------------------------------
	// model and helpers
	// --------------------------------
	function automatic int model_next(input int cur, input logic [7:0] op, input logic busy);
		if (cur == PS_SLEEP)
			return (op == OPC_WAKE) ? PS_STANDBY : PS_SLEEP;
		if (op == OPC_SLEEP && !busy)
			return PS_SLEEP;
		return busy ? PS_ACTIVE : PS_STANDBY;
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// sel 0 ready, 1 done, 2 device state equal to the model
	task automatic wait_on(input int sel, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk_sys);
			#1;
			if ((sel == 0 && ready === 1'b1) || (sel == 1 && done === 1'b1) || (sel == 2 && power_state === m_state))
				break;
		end
		if (i == lim) begin
			n_errors++;
			$display("[ERR] wait %0d expected hit seen timeout", sel);
		end
	endtask

	task automatic settle();
		wait_on(2, 60);
		chk("power_state", 8'(m_state), {5'h00, power_state});
	endtask

	task automatic send(input logic [7:0] op);
		wait_on(0, 1000);
		cmd_opcode = op;
		cmd_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		m_state = model_next(m_state, op, busy_flag);
		wait_on(1, 1000);
		settle();
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// --------------------------------
	// test sequence
	// --------------------------------
	initial begin
		logic [7:0] op;
		seed = 32'h3142;
		n_errors = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		vcc_ok = 1'b0;
		busy_flag = 1'b0;
		quad_enable = 1'b0;
		cmd_valid = 1'b0;
		cmd_opcode = 8'h00;
		hw_reset_req = 1'b0;
		m_state = PS_STANDBY;
		repeat (5) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		vcc_ok = 1'b1;
		repeat (PU / 2) @(posedge clk_sys);
		#1;
		chk("in_reset", 8'h01, {7'h00, in_reset});
		chk("ready", 8'h00, {7'h00, ready});
		settle();
		$display("test powerup finished");
		for (int k = 0; k < 4; k++) begin
			op = 8'($random(seed));
			if (op == OPC_SLEEP || op == OPC_WAKE)
				op = op ^ 8'h01;
			send(op);
		end
		$display("test plain commands finished");
		busy_flag = 1'b1;
		send(OPC_SLEEP);
		chk("miso", 8'h01, {7'h00, lnk_if.miso});
		busy_flag = 1'b0;
		m_state = PS_STANDBY;
		settle();
		chk("miso", 8'h00, {7'h00, lnk_if.miso});
		$display("test busy refusal finished");
		send(OPC_SLEEP);
		chk("miso_oe", 8'h00, {7'h00, lnk_if.miso_oe});
		send(8'($random(seed)) & 8'h7f);
		send(OPC_SLEEP);
		send(OPC_WAKE);
		$display("test deep sleep finished");
		for (int q = 0; q < 2; q++) begin
			quad_enable = q[0];
			wait_on(0, 1000);
			hw_reset_req = 1'b1;
			@(posedge clk_sys);
			#1;
			hw_reset_req = 1'b0;
			wait_on(1, 5000);
			settle();
			chk("reg_restore count", 8'(q + 1), 8'(restore_q.size()));
		end
		$display("test pin reset finished");
		vcc_ok = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("power_state", 8'(PS_POR), {5'h00, power_state});
		vcc_ok = 1'b1;
		settle();
		$display("test supply drop finished");
		report_and_stop();
	end

	initial begin
		#300000;
		n_errors++;
		$display("[ERR] watchdog expected finish seen timeout");
		report_and_stop();
	end
endmodule
